// file: src/uim_pkg.sv
package uim_pkg;
  // Serial character: start, nine data bits lsb first, one stop bit
  localparam int unsigned CLKS_PER_BIT   = 16;
  localparam int unsigned CHAR_BITS      = 9;
  localparam int unsigned ADDR_MARK_BIT  = 8;
  localparam int unsigned TX_RELOAD_BITS = 7;

  localparam logic [7:0] OFS_TXDATA  = 8'h00;
  localparam logic [7:0] OFS_RXDATA  = 8'h04;
  localparam logic [7:0] OFS_STAT0   = 8'h08;
  localparam logic [7:0] OFS_STAT1   = 8'h0c;
  localparam logic [7:0] OFS_CTRL    = 8'h10;
  localparam logic [7:0] OFS_ADDRCMP = 8'h14;

  localparam int unsigned ST0_RXAVAIL = 0;
  localparam int unsigned ST0_TXEMPTY = 1;
  localparam int unsigned ST0_OVERRUN = 2;
  localparam int unsigned ST0_FRAMING = 3;
  localparam int unsigned ST0_BREAK   = 4;
  localparam int unsigned ST0_TXIDLE  = 5;
  localparam int unsigned ST1_NEW_FRAME_FLAG  = 0;
  localparam int unsigned ST1_ADDRRX  = 1;

  localparam int unsigned CTL_MULTIPROC_ENABLE    = 0;
  localparam int unsigned CTL_MODE    = 1;
  localparam int unsigned CTL_RXDIE   = 3;
  localparam int unsigned CTL_RXEIE   = 4;
  localparam int unsigned CTL_TXIE    = 5;
  localparam int unsigned CTL_RXEN    = 6;
  localparam int unsigned CTL_WIDTH   = 7;

  localparam logic [6:0] CTRL_RESET    = 7'h00;
  localparam logic [7:0] ADDRCMP_RESET = 8'h00;

  localparam logic [1:0] MODE_ALL        = 2'h0;
  localparam logic [1:0] MODE_ADDR_ONLY  = 2'h1;
  localparam logic [1:0] MODE_MATCH      = 2'h2;
  localparam logic [1:0] MODE_MATCH_DATA = 2'h3;

  typedef enum logic [3:0] {
    UIM_S_IDLE  = 4'h1,
    UIM_S_START = 4'h2,
    UIM_S_DATA  = 4'h4,
    UIM_S_STOP  = 4'h8
  } uim_ser_e;
endpackage : uim_pkg

// file: src/uim_link_if.sv
`timescale 1ns/1ps
interface uim_link_if;
  logic node_to_dev;
  logic dev_to_node;
  modport dev (input node_to_dev, output dev_to_node);
  modport node (input dev_to_node, output node_to_dev);
endinterface : uim_link_if

// file: src/uim_tx.sv
`timescale 1ns/1ps
module uim_tx #(
  parameter int unsigned CLKS_PER_BIT = uim_pkg::CLKS_PER_BIT,
  parameter int unsigned CHAR_BITS    = uim_pkg::CHAR_BITS
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rst_b,
  input  wire logic                 load,
  input  wire logic [CHAR_BITS-1:0] data,
  output logic                      busy,
  output logic                      first_bit_done,
  output logic                      ser_out
);
  localparam int unsigned CW = $clog2(CLKS_PER_BIT);
  localparam int unsigned BW = $clog2(CHAR_BITS + 1);

  uim_pkg::uim_ser_e    state_reg;
  logic [CW-1:0]        clk_cnt_reg;
  logic [BW-1:0]        bit_cnt_reg;
  logic [CHAR_BITS-1:0] shift_reg;
  logic                 bit_end;

  assign bit_end = (clk_cnt_reg == CW'(CLKS_PER_BIT - 1));
  assign busy    = (state_reg != uim_pkg::UIM_S_IDLE);

  always_ff @(posedge sys_clk) begin
    if (!rst_b || state_reg == uim_pkg::UIM_S_IDLE || bit_end) begin
      clk_cnt_reg <= '0;
    end else begin
      clk_cnt_reg <= clk_cnt_reg + CW'(1);
    end
  end

  // Pulse once the start bit has fully left the shifter
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      first_bit_done <= 1'b0;
    end else begin
      first_bit_done <= (state_reg == uim_pkg::UIM_S_START) && bit_end;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state_reg   <= uim_pkg::UIM_S_IDLE;
      shift_reg   <= '0;
      bit_cnt_reg <= '0;
      ser_out     <= 1'b1;
    end else begin
      unique case (state_reg)
        uim_pkg::UIM_S_IDLE: if (load) begin
          state_reg <= uim_pkg::UIM_S_START;
          shift_reg <= data;
          ser_out   <= 1'b0;
        end
        uim_pkg::UIM_S_START: if (bit_end) begin
          state_reg   <= uim_pkg::UIM_S_DATA;
          ser_out     <= shift_reg[0];
          shift_reg   <= shift_reg >> 1;
          bit_cnt_reg <= '0;
        end
        uim_pkg::UIM_S_DATA: if (bit_end) begin
          if (bit_cnt_reg == BW'(CHAR_BITS - 1)) begin
            state_reg <= uim_pkg::UIM_S_STOP;
            ser_out   <= 1'b1;
          end else begin
            ser_out     <= shift_reg[0];
            shift_reg   <= shift_reg >> 1;
            bit_cnt_reg <= bit_cnt_reg + BW'(1);
          end
        end
        uim_pkg::UIM_S_STOP: if (bit_end) begin
          state_reg <= uim_pkg::UIM_S_IDLE;
        end
      endcase
    end
  end
endmodule : uim_tx

// file: src/uim_node.sv
`timescale 1ns/1ps
module uim_node #(
  parameter int unsigned CLKS_PER_BIT = uim_pkg::CLKS_PER_BIT
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  uim_link_if.node         link,
  input  wire logic        send_valid,
  input  wire logic [8:0]  send_data,
  output logic             send_ready,
  output logic             recv_valid,
  output logic [8:0]       recv_data,
  output logic             recv_err
);
  localparam int unsigned CW = $clog2(CLKS_PER_BIT);

  logic              tx_busy;
  logic              tx_load;
  uim_pkg::uim_ser_e rx_state_reg;
  logic [CW-1:0]     rx_cnt_reg;
  logic [3:0]        rx_bits_reg;
  logic [8:0]        rx_shift_reg;
  logic              rx_meta_reg;
  logic              rx_sync_reg;
  logic              rx_prev_reg;
  logic              rx_bit_end;
  logic              rx_half;

  // Ninth bit set marks an address character for the far device
  assign tx_load = send_valid && send_ready;

  uim_tx #(.CLKS_PER_BIT(CLKS_PER_BIT), .CHAR_BITS(uim_pkg::CHAR_BITS)) u_tx (
    .sys_clk        (sys_clk),
    .rst_b          (rst_b),
    .load           (tx_load),
    .data           (send_data),
    .busy           (tx_busy),
    .first_bit_done (),
    .ser_out        (link.node_to_dev)
  );

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      send_ready <= 1'b0;
    end else begin
      send_ready <= !tx_busy && !tx_load;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
      rx_prev_reg <= 1'b1;
    end else begin
      rx_meta_reg <= link.dev_to_node;
      rx_sync_reg <= rx_meta_reg;
      rx_prev_reg <= rx_sync_reg;
    end
  end

  assign rx_bit_end = (rx_cnt_reg == CW'(CLKS_PER_BIT - 1));
  assign rx_half    = (rx_cnt_reg == CW'(CLKS_PER_BIT / 2 - 1));

  always_ff @(posedge sys_clk) begin
    if (!rst_b || rx_state_reg == uim_pkg::UIM_S_IDLE || rx_bit_end ||
        (rx_state_reg == uim_pkg::UIM_S_START && rx_half)) begin
      rx_cnt_reg <= '0;
    end else begin
      rx_cnt_reg <= rx_cnt_reg + CW'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rx_state_reg <= uim_pkg::UIM_S_IDLE;
      rx_bits_reg  <= '0;
      rx_shift_reg <= '0;
      recv_valid   <= 1'b0;
      recv_data    <= '0;
      recv_err     <= 1'b0;
    end else begin
      recv_valid <= 1'b0;
      unique case (rx_state_reg)
        uim_pkg::UIM_S_IDLE: if (rx_prev_reg && !rx_sync_reg) begin
          rx_state_reg <= uim_pkg::UIM_S_START;
        end
        uim_pkg::UIM_S_START: if (rx_half) begin
          rx_state_reg <= rx_sync_reg ? uim_pkg::UIM_S_IDLE : uim_pkg::UIM_S_DATA;
          rx_bits_reg  <= '0;
        end
        uim_pkg::UIM_S_DATA: if (rx_bit_end) begin
          rx_shift_reg <= {rx_sync_reg, rx_shift_reg[8:1]};
          rx_bits_reg  <= rx_bits_reg + 4'h1;
          if (rx_bits_reg == 4'(uim_pkg::CHAR_BITS - 1)) begin
            rx_state_reg <= uim_pkg::UIM_S_STOP;
          end
        end
        uim_pkg::UIM_S_STOP: if (rx_bit_end) begin
          rx_state_reg <= uim_pkg::UIM_S_IDLE;
          recv_valid   <= 1'b1;
          recv_data    <= rx_shift_reg;
          recv_err     <= !rx_sync_reg;
        end
      endcase
    end
  end
endmodule : uim_node

// file: src/uim_dev.sv
// The APB register port and the register offsets were decided locally.
`timescale 1ns/1ps
module uim_dev #(
  parameter int unsigned CLKS_PER_BIT = uim_pkg::CLKS_PER_BIT
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  uim_link_if.dev          link,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             rx_irq,
  output logic             tx_irq
);
  localparam int unsigned CW = $clog2(CLKS_PER_BIT);

  logic [uim_pkg::CTL_WIDTH-1:0] ctrl_reg;
  logic [7:0]        addrcmp_reg;
  logic [8:0]        tx_hold_reg;
  logic              tx_hold_full_reg;
  logic              tx_holding_empty_reg;
  logic              tx_busy;
  logic              tx_first_bit;
  logic              tx_load;
  logic [8:0]        rx_data_reg;
  logic              rx_byte_available_reg;
  logic              overrun_reg;
  logic              framing_reg;
  logic              line_break_detected_reg;
  logic              ovr_pend_reg;
  logic              brk_pend_reg;
  logic              new_frame_flag_reg;
  logic              addr_byte_received_reg;
  logic              in_frame_reg;
  logic              first_pend_reg;
  uim_pkg::uim_ser_e rx_state_reg;
  logic [CW-1:0]     rx_cnt_reg;
  logic [3:0]        rx_bits_reg;
  logic [8:0]        rx_shift_reg;
  logic              rx_meta_reg;
  logic              rx_sync_reg;
  logic              rx_prev_reg;
  logic              rx_bit_end;
  logic              rx_half;
  logic              char_done;
  logic              acc;
  logic              wr_tx;
  logic              rd_rx;
  logic              multiproc_enable;
  logic [1:0]        addr_match_mode;
  logic              is_addr;
  logic              addr_hit;
  logic              brk_char;
  logic              accept;
  logic              store;
  logic              nf;
  logic              in_frame_next;
  logic              first_pend_next;
  logic [31:0]       rd_val;
  logic              hit;

  assign multiproc_enable = ctrl_reg[uim_pkg::CTL_MULTIPROC_ENABLE];
  assign addr_match_mode  = ctrl_reg[uim_pkg::CTL_MODE +: 2];

  // Register access completes on the second access-phase edge
  assign acc   = psel && penable && pready;
  assign wr_tx = acc && pwrite && paddr == uim_pkg::OFS_TXDATA;
  assign rd_rx = acc && !pwrite && paddr == uim_pkg::OFS_RXDATA;

  always_comb begin
    rd_val = 32'h0;
    hit    = 1'b1;
    unique case (paddr)
      uim_pkg::OFS_TXDATA:  rd_val = {23'h0, tx_hold_reg};
      uim_pkg::OFS_RXDATA:  rd_val = {23'h0, rx_data_reg};
      uim_pkg::OFS_STAT0:   rd_val = {26'h0, !tx_busy && !tx_hold_full_reg, line_break_detected_reg,
                                      framing_reg, overrun_reg, tx_holding_empty_reg, rx_byte_available_reg};
      uim_pkg::OFS_STAT1:   rd_val = {30'h0, addr_byte_received_reg, new_frame_flag_reg};
      uim_pkg::OFS_CTRL:    rd_val = {25'h0, ctrl_reg};
      uim_pkg::OFS_ADDRCMP: rd_val = {24'h0, addrcmp_reg};
      default:              hit    = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && penable && !pready;
      prdata  <= (psel && penable && !pready && !pwrite) ? rd_val : 32'h0;
      pslverr <= psel && penable && !pready && !hit;
    end
  end

  // Software owns enabling the mode and picking the scheme
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ctrl_reg    <= uim_pkg::CTRL_RESET;
      addrcmp_reg <= uim_pkg::ADDRCMP_RESET;
    end else if (acc && pwrite) begin
      if (paddr == uim_pkg::OFS_CTRL) begin
        ctrl_reg <= pwdata[uim_pkg::CTL_WIDTH-1:0];
      end
      if (paddr == uim_pkg::OFS_ADDRCMP) begin
        addrcmp_reg <= pwdata[7:0];
      end
    end
  end

  // Transmit path: holding register feeds the shifter
  assign tx_load = tx_hold_full_reg && !tx_busy;

  uim_tx #(.CLKS_PER_BIT(CLKS_PER_BIT), .CHAR_BITS(uim_pkg::CHAR_BITS)) u_tx (
    .sys_clk        (sys_clk),
    .rst_b          (rst_b),
    .load           (tx_load),
    .data           (tx_hold_reg),
    .busy           (tx_busy),
    .first_bit_done (tx_first_bit),
    .ser_out        (link.dev_to_node)
  );

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      tx_hold_reg      <= '0;
      tx_hold_full_reg <= 1'b0;
    end else if (wr_tx) begin
      tx_hold_reg      <= pwdata[8:0];
      tx_hold_full_reg <= 1'b1;
    end else if (tx_load) begin
      tx_hold_full_reg <= 1'b0;
    end
  end

  // Hardware set wins over a same-cycle write; reload window is the nine data bits and the stop bit
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      tx_holding_empty_reg <= 1'b1;
    end else if (tx_first_bit) begin
      tx_holding_empty_reg <= 1'b1;
    end else if (wr_tx) begin
      tx_holding_empty_reg <= 1'b0;
    end
  end

  // Receive line passes two flops before any logic looks at it
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
      rx_prev_reg <= 1'b1;
    end else begin
      rx_meta_reg <= link.node_to_dev;
      rx_sync_reg <= rx_meta_reg;
      rx_prev_reg <= rx_sync_reg;
    end
  end

  assign rx_bit_end = (rx_cnt_reg == CW'(CLKS_PER_BIT - 1));
  assign rx_half    = (rx_cnt_reg == CW'(CLKS_PER_BIT / 2 - 1));
  assign char_done  = (rx_state_reg == uim_pkg::UIM_S_STOP) && rx_bit_end;

  always_ff @(posedge sys_clk) begin
    if (!rst_b || rx_state_reg == uim_pkg::UIM_S_IDLE || rx_bit_end ||
        (rx_state_reg == uim_pkg::UIM_S_START && rx_half)) begin
      rx_cnt_reg <= '0;
    end else begin
      rx_cnt_reg <= rx_cnt_reg + CW'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rx_state_reg <= uim_pkg::UIM_S_IDLE;
      rx_bits_reg  <= '0;
      rx_shift_reg <= '0;
    end else begin
      unique case (rx_state_reg)
        uim_pkg::UIM_S_IDLE: if (ctrl_reg[uim_pkg::CTL_RXEN] && rx_prev_reg && !rx_sync_reg) begin
          rx_state_reg <= uim_pkg::UIM_S_START;
        end
        uim_pkg::UIM_S_START: if (rx_half) begin
          rx_state_reg <= rx_sync_reg ? uim_pkg::UIM_S_IDLE : uim_pkg::UIM_S_DATA;
          rx_bits_reg  <= '0;
        end
        uim_pkg::UIM_S_DATA: if (rx_bit_end) begin
          rx_shift_reg <= {rx_sync_reg, rx_shift_reg[8:1]};
          rx_bits_reg  <= rx_bits_reg + 4'h1;
          if (rx_bits_reg == 4'(uim_pkg::CHAR_BITS - 1)) begin
            rx_state_reg <= uim_pkg::UIM_S_STOP;
          end
        end
        uim_pkg::UIM_S_STOP: if (rx_bit_end) begin
          rx_state_reg <= uim_pkg::UIM_S_IDLE;
        end
      endcase
    end
  end

  // Address filter; ninth bit is data when the mode is off
  assign is_addr  = multiproc_enable && rx_shift_reg[uim_pkg::ADDR_MARK_BIT];
  assign addr_hit = (rx_shift_reg[7:0] == addrcmp_reg);
  assign brk_char = !rx_sync_reg && rx_shift_reg == 9'h000;

  always_comb begin
    accept          = 1'b1;
    nf              = 1'b0;
    in_frame_next   = in_frame_reg;
    first_pend_next = first_pend_reg;
    if (multiproc_enable) begin
      unique case (addr_match_mode)
        uim_pkg::MODE_ALL:       accept = 1'b1;
        uim_pkg::MODE_ADDR_ONLY: accept = is_addr;
        uim_pkg::MODE_MATCH, uim_pkg::MODE_MATCH_DATA: begin
          if (is_addr) begin
            in_frame_next   = addr_hit;
            first_pend_next = addr_hit;
            accept          = addr_hit && addr_match_mode == uim_pkg::MODE_MATCH;
          end else begin
            accept = in_frame_reg;
            nf     = in_frame_reg && first_pend_reg;
            if (in_frame_reg) begin
              first_pend_next = 1'b0;
            end
          end
        end
      endcase
    end
  end

  // Errors always reach software, even from filtered characters
  assign store = char_done && (accept || !rx_sync_reg);

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      in_frame_reg   <= 1'b0;
      first_pend_reg <= 1'b0;
    end else if (char_done) begin
      in_frame_reg   <= in_frame_next;
      first_pend_reg <= first_pend_next;
    end
  end

  // A new character sets over a same-cycle read clear
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rx_data_reg             <= '0;
      rx_byte_available_reg   <= 1'b0;
      overrun_reg             <= 1'b0;
      framing_reg             <= 1'b0;
      line_break_detected_reg <= 1'b0;
      ovr_pend_reg            <= 1'b0;
      brk_pend_reg            <= 1'b0;
      new_frame_flag_reg      <= 1'b0;
      addr_byte_received_reg  <= 1'b0;
    end else begin
      if (rd_rx) begin
        if (ovr_pend_reg) begin
          overrun_reg             <= 1'b1;
          line_break_detected_reg <= brk_pend_reg;
          ovr_pend_reg            <= 1'b0;
        end else begin
          rx_byte_available_reg   <= 1'b0;
          overrun_reg             <= 1'b0;
          framing_reg             <= 1'b0;
          line_break_detected_reg <= 1'b0;
        end
      end
      if (store) begin
        if (rx_byte_available_reg && !(rd_rx && !ovr_pend_reg)) begin
          ovr_pend_reg <= 1'b1;
          brk_pend_reg <= brk_char;
        end else begin
          rx_data_reg             <= rx_shift_reg;
          rx_byte_available_reg   <= 1'b1;
          framing_reg             <= !rx_sync_reg;
          line_break_detected_reg <= brk_char;
          addr_byte_received_reg  <= is_addr;
          new_frame_flag_reg      <= nf;
        end
      end
    end
  end

  // Levels, held until software clears the cause
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rx_irq <= 1'b0;
      tx_irq <= 1'b0;
    end else begin
      rx_irq <= (rx_byte_available_reg && ctrl_reg[uim_pkg::CTL_RXDIE]) ||
                ((overrun_reg || framing_reg || line_break_detected_reg) &&
                 ctrl_reg[uim_pkg::CTL_RXEIE]);
      tx_irq <= tx_holding_empty_reg && ctrl_reg[uim_pkg::CTL_TXIE];
    end
  end
endmodule : uim_dev

// file: tb/uim_link_props.sv
`timescale 1ns/1ps
module uim_link_props #(
  parameter int unsigned CLKS_PER_BIT = uim_pkg::CLKS_PER_BIT
) (
  input wire logic        sys_clk,
  input wire logic        rst_b,
  input wire logic        node_to_dev,
  input wire logic        dev_to_node,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic        rx_irq,
  input wire logic        tx_irq
);
  // Low-run length of each line; idle high runs are unbounded, so only low runs are judged
  logic        dprev;
  logic        nprev;
  logic [15:0] dcnt;
  logic [15:0] ncnt;

  always_ff @(posedge sys_clk) begin
    dprev <= dev_to_node;
    nprev <= node_to_dev;
    dcnt  <= (!rst_b || dev_to_node != dprev) ? 16'h0001 : dcnt + 16'h0001;
    ncnt  <= (!rst_b || node_to_dev != nprev) ? 16'h0001 : ncnt + 16'h0001;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  a_access_one_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("pready not after one wait state");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside answer");
  a_unmapped_err: assert property (psel && penable && pready && paddr > 8'h14 |-> pslverr)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (psel && penable && pready && paddr[1:0] == 2'h0 && paddr <= 8'h14 |-> !pslverr)
    else $error("mapped access refused");
  a_dev_bit_time: assert property (!dprev && dev_to_node |-> dcnt % CLKS_PER_BIT == 16'h0)
    else $error("device bit time wrong");
  a_node_bit_time: assert property (!nprev && node_to_dev |-> ncnt % CLKS_PER_BIT == 16'h0)
    else $error("node bit time wrong");
  a_rx_irq_line: assert property ($rose(rx_irq) |-> node_to_dev)
    else $error("receive interrupt before stop bit");

  c_refused: cover property (pslverr);
  c_rx_irq: cover property ($rose(rx_irq));
  c_tx_irq: cover property ($rose(tx_irq));
endmodule : uim_link_props

// file: tb/tb_uart_irq_multiprocessor_filter.sv
`timescale 1ns/1ps
module tb_uart_irq_multiprocessor_filter;
  localparam int unsigned CPB = 8;
  logic        sys_clk;
  logic        rst_b = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        send_valid = 1'b0;
  logic [8:0]  send_data = 9'h000;
  logic [31:0] prdata, rd;
  logic [8:0]  recv_data;
  logic        pready, pslverr, rx_irq, tx_irq, send_ready, recv_valid, err, recv_err;
  int          err_count, n_tests, cyc, k;

  uim_link_if uim_link_if_i ();
  uim_dev #(.CLKS_PER_BIT(CPB)) uim_dev_i (.sys_clk(sys_clk), .rst_b(rst_b), .link(uim_link_if_i), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_irq(rx_irq), .tx_irq(tx_irq));
  uim_node #(.CLKS_PER_BIT(CPB)) uim_node_i (.sys_clk(sys_clk), .rst_b(rst_b), .link(uim_link_if_i),
    .send_valid(send_valid), .send_data(send_data), .send_ready(send_ready), .recv_valid(recv_valid),
    .recv_data(recv_data), .recv_err(recv_err));
  uim_link_props #(.CLKS_PER_BIT(CPB)) uim_link_props_i (.sys_clk(sys_clk), .rst_b(rst_b),
    .node_to_dev(uim_link_if_i.node_to_dev), .dev_to_node(uim_link_if_i.dev_to_node), .paddr(paddr),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata), .rx_irq(rx_irq),
    .tx_irq(tx_irq));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic conclude();
    if (err_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Idle cycle after each transfer keeps psel from being written twice in one step
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    psel   <= 1'b1;
    paddr  <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    check(rd, exp);
  endtask : rchk

  task automatic send(input logic [8:0] d);
    while (send_ready !== 1'b1) @(posedge sys_clk);
    send_valid <= 1'b1;
    send_data  <= d;
    @(posedge sys_clk);
    send_valid <= 1'b0;
    @(posedge sys_clk);
    while (send_ready !== 1'b1) @(posedge sys_clk);
  endtask : send

  task automatic rx(input logic [8:0] d, input logic irq, input logic [31:0] s1);
    send(d);
    check({31'h0, rx_irq}, {31'h0, irq});
    if (irq) begin
      rchk(uim_pkg::OFS_STAT1, s1);
      rchk(uim_pkg::OFS_RXDATA, {23'h0, d});
    end
  endtask : rx

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      conclude();
    end
  end

  initial begin
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    rchk(uim_pkg::OFS_CTRL, 32'h0);
    rchk(uim_pkg::OFS_ADDRCMP, 32'h0);
    rchk(uim_pkg::OFS_STAT0, 32'h22);
    apb(8'h18, 1'b0, 32'h0);
    check({31'h0, err}, 32'h1);
    apb(uim_pkg::OFS_ADDRCMP, 1'b1, 32'h5a);
    apb(uim_pkg::OFS_CTRL, 1'b1, 32'h4d);
    rx(9'h133, 1'b0, 32'h0);
    rx(9'h011, 1'b0, 32'h0);
    rx(9'h15a, 1'b1, 32'h2);
    rx(9'h0a1, 1'b1, 32'h1);
    rx(9'h0a2, 1'b1, 32'h0);
    rx(9'h166, 1'b0, 32'h0);
    rx(9'h0a3, 1'b0, 32'h0);
    apb(uim_pkg::OFS_CTRL, 1'b1, 32'h4f);
    rx(9'h15a, 1'b0, 32'h0);
    rx(9'h0b1, 1'b1, 32'h1);
    apb(uim_pkg::OFS_CTRL, 1'b1, 32'h4b);
    rx(9'h0c1, 1'b0, 32'h0);
    rx(9'h1c3, 1'b1, 32'h2);
    apb(uim_pkg::OFS_CTRL, 1'b1, 32'h49);
    rx(9'h0c4, 1'b1, 32'h0);
    send(9'h0d1);
    send(9'h0d2);
    rchk(uim_pkg::OFS_STAT0, 32'h23);
    rchk(uim_pkg::OFS_RXDATA, 32'h0d1);
    rchk(uim_pkg::OFS_STAT0, 32'h27);
    rchk(uim_pkg::OFS_RXDATA, 32'h0d1);
    rchk(uim_pkg::OFS_STAT0, 32'h22);
    apb(uim_pkg::OFS_CTRL, 1'b1, 32'h41);
    send(9'h0e1);
    check({31'h0, rx_irq}, 32'h0);
    apb(uim_pkg::OFS_CTRL, 1'b1, 32'h49);
    rchk(uim_pkg::OFS_STAT0, 32'h23);
    check({31'h0, rx_irq}, 32'h1);
    rchk(uim_pkg::OFS_RXDATA, 32'h0e1);
    apb(uim_pkg::OFS_CTRL, 1'b1, 32'h61);
    apb(uim_pkg::OFS_TXDATA, 1'b1, 32'h1e5);
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (tx_irq !== 1'b1 && k < 200);
    check(32'(k >= CPB - 1 && k <= 2 * CPB), 32'h1);
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (recv_valid !== 1'b1 && k < 400);
    check({23'h0, recv_data}, 32'h1e5);
    check({31'h0, recv_err}, 32'h0);
    conclude();
  end
endmodule : tb_uart_irq_multiprocessor_filter
